// ### pkg/flow_pkg.sv
// Constants and types for the return stack and program counter control block
package flow_pkg;
  localparam int PC_W = 21;
  localparam int SP_W = 5;
  localparam int DEPTH = 31;
  localparam logic [SP_W-1:0] SP_MAX = 5'h1F;
  localparam logic [SP_W-1:0] SP_ZERO = 5'h00;
  localparam logic [PC_W-1:0] PC_ZERO = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int FULL_BIT = 7;
  localparam int UNF_BIT = 6;
  // Register indices on the plain port
  localparam logic [3:0] REG_SP = 4'h0;
  localparam logic [3:0] REG_TOS_LOW = 4'h1;
  localparam logic [3:0] REG_TOS_HIGH = 4'h2;
  localparam logic [3:0] REG_TOS_UPPER = 4'h3;
  localparam logic [3:0] REG_PC_LOW = 4'h4;
  localparam logic [3:0] REG_PC_HIGH_HOLD = 4'h5;
  localparam logic [3:0] REG_PC_UPPER_HOLD = 4'h6;
  localparam logic [3:0] REG_CONFIG = 4'h7;
  localparam logic CFG_RESET_VALUE = 1'b1;
  // Q phases, Gray order
  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b11,
    Q4 = 2'b10
  } phase_e;
  typedef logic [PC_W-1:0] pc_t;
endpackage

// ### design/return_stack_and_pc_control.sv
// Return address stack, fast shadow registers and program counter control
// Functional notes
// - Pointer 0..31, increments on push, decrements on pop, zero after any reset.
// - Full flag set after 31 pushes, cleared only by software or power-on reset.
// - Error reset enabled: 31st push stores PC+2, sets full, resets, pointer to 0.
// - Error reset disabled: 31st push sets full; later pushes overwrite entry 31.
// - Pop on empty loads PC zero, sets underflow flag, pointer stays 0.
// - Enabled error reset: flag set first then device reset; disabled: flag only.
// - Pointer register: bit7 full, bit6 underflow, bit5 zero, bits4-0 pointer.
// - Software can read and overwrite the pointer value.
// - Push instruction increments pointer and stores current PC in new top.
// - Pop instruction only decrements pointer, exposing previous entry.
// - Hidden one-deep shadow of status, working, bank loaded on interrupt vector.
// - Fast return restores shadow; fast call also captures it.
// - PC is 21 bits; only low byte direct, upper parts via holding registers.
// - PC bit0 always zero; sequential advance by two.
// - Call, relative call, goto, branch load PC directly, holding regs untouched.
// - Writing PC low byte loads high and upper bytes from holding registers.
// - Reading PC low byte copies high and upper bytes into holding registers.
// - Clock divided into four phases; PC increments Q1, instruction latched Q4.
// - Fetch overlaps execute; data memory read in Q2, written in Q4.
// - PC-changing instructions take two cycles; fetched instruction flushed as no-op.
// - Storage is 31 entries of 21 bits; pointer zero has no entry.
// - Push increments before writing; pop reads before decrementing.
// - Top-of-stack registers show and replace the entry selected by pointer.
`timescale 1ns/1ns
`default_nettype none
module return_stack_and_pc_control
  import flow_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Decoder requests, each sampled in Q4 of the execute cycle
  input wire logic push_req,
  input wire logic pop_req,
  input wire logic irq_vector,
  input wire logic fast_call,
  input wire logic fast_return,
  input wire logic jump_req,
  input wire logic [flow_pkg::PC_W-1:0] jump_target,
  input wire logic [15:0] fetch_data,
  // Core registers to shadow
  input wire logic [7:0] status_in,
  input wire logic [7:0] working_in,
  input wire logic [7:0] bank_in,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Program flow outputs
  output logic [flow_pkg::PC_W-1:0] pc_out,
  output logic [15:0] instruction_register,
  output logic flush_active,
  output logic [1:0] phase_out,
  output logic data_read_strobe,
  output logic data_write_strobe,
  output logic restore_valid,
  output logic [7:0] status_restore,
  output logic [7:0] working_restore,
  output logic [7:0] bank_restore,
  output logic stack_reset_req
);

  import flow_pkg::*;

  phase_e phase_q, phase_d;
  pc_t pc_q, pc_d;
  logic [SP_W-1:0] sp_q, sp_d;
  logic full_q, full_d, unf_q, unf_d;
  logic cfg_q, cfg_d;
  pc_t stack_q [DEPTH];
  pc_t stack_d [DEPTH];
  logic [7:0] hold_high_q, hold_high_d, hold_upper_q, hold_upper_d;
  logic [15:0] ir_q, ir_d;
  logic flush_q, flush_d;
  logic [7:0] sh_stat_q, sh_stat_d, sh_work_q, sh_work_d, sh_bank_q, sh_bank_d;
  logic restore_q, restore_d;
  logic rst_req_q, rst_req_d;
  logic [7:0] rdata_q, rdata_d;
  logic rd_strb_q, rd_strb_d, wr_strb_q, wr_strb_d;
  logic do_push, do_pop, exec_q4;
  logic [SP_W-1:0] idx;
  pc_t tos;

  assign exec_q4 = (phase_q == Q4) && !flush_q;
  assign do_push = exec_q4 && (push_req || irq_vector);
  assign do_pop = exec_q4 && pop_req && !do_push;
  assign idx = (sp_q == SP_ZERO) ? SP_ZERO : sp_q - 5'h01;
  assign tos = (sp_q == SP_ZERO) ? PC_ZERO : stack_q[idx];

  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      Q1: phase_d = Q2;
      Q2: phase_d = Q3;
      Q3: phase_d = Q4;
      Q4: phase_d = Q1;
      default: phase_d = Q1;
    endcase
  end

  always_comb begin
    pc_d = pc_q;
    sp_d = sp_q;
    full_d = full_q;
    unf_d = unf_q;
    cfg_d = cfg_q;
    stack_d = stack_q;
    hold_high_d = hold_high_q;
    hold_upper_d = hold_upper_q;
    ir_d = ir_q;
    flush_d = flush_q;
    sh_stat_d = sh_stat_q;
    sh_work_d = sh_work_q;
    sh_bank_d = sh_bank_q;
    restore_d = 1'b0;
    rst_req_d = 1'b0;
    rdata_d = BYTE_ZERO;
    rd_strb_d = (phase_q == Q1) && !flush_q;
    wr_strb_d = (phase_q == Q3) && !flush_q;
    if (phase_q == Q4) begin
      pc_d = pc_q + PC_STEP;
      ir_d = fetch_data;
      flush_d = 1'b0;
    end
    // Software accesses first so hardware stack operations override them
    if (reg_wr) begin
      case (reg_addr)
        REG_SP: begin
          sp_d = reg_wdata[SP_W-1:0];
          if (!reg_wdata[FULL_BIT]) full_d = 1'b0;
          if (!reg_wdata[UNF_BIT]) unf_d = 1'b0;
        end
        REG_TOS_LOW: if (sp_q != SP_ZERO) stack_d[idx][7:0] = reg_wdata;
        REG_TOS_HIGH: if (sp_q != SP_ZERO) stack_d[idx][15:8] = reg_wdata;
        REG_TOS_UPPER: if (sp_q != SP_ZERO) stack_d[idx][20:16] = reg_wdata[4:0];
        REG_PC_LOW: begin
          pc_d = {hold_upper_q[4:0], hold_high_q, reg_wdata[7:1], 1'b0};
          flush_d = 1'b1;
        end
        REG_PC_HIGH_HOLD: hold_high_d = reg_wdata;
        REG_PC_UPPER_HOLD: hold_upper_d = {3'b000, reg_wdata[4:0]};
        REG_CONFIG: cfg_d = reg_wdata[0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_SP: rdata_d = {full_q, unf_q, 1'b0, sp_q};
        REG_TOS_LOW: rdata_d = tos[7:0];
        REG_TOS_HIGH: rdata_d = tos[15:8];
        REG_TOS_UPPER: rdata_d = {3'b000, tos[20:16]};
        REG_PC_LOW: begin
          rdata_d = pc_q[7:0];
          hold_high_d = pc_q[15:8];
          hold_upper_d = {3'b000, pc_q[20:16]};
        end
        REG_PC_HIGH_HOLD: rdata_d = hold_high_q;
        REG_PC_UPPER_HOLD: rdata_d = hold_upper_q;
        REG_CONFIG: rdata_d = {7'h00, cfg_q};
        default: rdata_d = BYTE_ZERO;
      endcase
    end
    if (do_push) begin
      if (sp_q == SP_MAX) begin
        stack_d[DEPTH-1] = pc_q;
      end else if (sp_q == SP_MAX - 5'h01) begin
        full_d = 1'b1;
        stack_d[sp_q] = cfg_q ? pc_q + PC_STEP : pc_q;
        sp_d = cfg_q ? SP_ZERO : SP_MAX;
        rst_req_d = cfg_q;
      end else begin
        sp_d = sp_q + 5'h01;
        stack_d[sp_q] = pc_q;
      end
    end
    if (do_pop) begin
      if (sp_q == SP_ZERO) begin
        unf_d = 1'b1;
        rst_req_d = cfg_q;
        if (!push_req) pc_d = PC_ZERO;
      end else begin
        sp_d = sp_q - 5'h01;
      end
      // Return instructions reload PC from the entry read before decrement
      if (!push_req && sp_q != SP_ZERO && jump_req) pc_d = tos;
    end
    if (exec_q4 && irq_vector) begin
      sh_stat_d = status_in;
      sh_work_d = working_in;
      sh_bank_d = bank_in;
    end
    if (exec_q4 && fast_call) begin
      sh_stat_d = status_in;
      sh_work_d = working_in;
      sh_bank_d = bank_in;
    end
    if (exec_q4 && fast_return) restore_d = 1'b1;
    if (exec_q4 && jump_req && !do_pop) begin
      pc_d = {jump_target[PC_W-1:1], 1'b0};
    end
    if (exec_q4 && (jump_req || do_pop || (do_push && push_req == 1'b0))) flush_d = 1'b1;
    if (exec_q4 && do_pop && sp_q == SP_ZERO) flush_d = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_q <= Q1;
      pc_q <= PC_ZERO;
      sp_q <= SP_ZERO;
      cfg_q <= CFG_RESET_VALUE;
      for (int i = 0; i < DEPTH; i++) stack_q[i] <= PC_ZERO;
      hold_high_q <= BYTE_ZERO;
      hold_upper_q <= BYTE_ZERO;
      ir_q <= 16'h0000;
      flush_q <= 1'b0;
      sh_stat_q <= BYTE_ZERO;
      sh_work_q <= BYTE_ZERO;
      sh_bank_q <= BYTE_ZERO;
      restore_q <= 1'b0;
      rst_req_q <= 1'b0;
      rdata_q <= BYTE_ZERO;
      rd_strb_q <= 1'b0;
      wr_strb_q <= 1'b0;
    end else if (rst_req_q) begin
      // Stack error reset: flags survive, flow restarts at zero
      phase_q <= Q1;
      pc_q <= PC_ZERO;
      sp_q <= SP_ZERO;
      flush_q <= 1'b1;
      rst_req_q <= 1'b0;
      restore_q <= 1'b0;
      rdata_q <= rdata_d;
      rd_strb_q <= 1'b0;
      wr_strb_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      pc_q <= pc_d;
      sp_q <= sp_d;
      cfg_q <= cfg_d;
      stack_q <= stack_d;
      hold_high_q <= hold_high_d;
      hold_upper_q <= hold_upper_d;
      ir_q <= ir_d;
      flush_q <= flush_d;
      sh_stat_q <= sh_stat_d;
      sh_work_q <= sh_work_d;
      sh_bank_q <= sh_bank_d;
      restore_q <= restore_d;
      rst_req_q <= rst_req_d;
      rdata_q <= rdata_d;
      rd_strb_q <= rd_strb_d;
      wr_strb_q <= wr_strb_d;
    end
  end

  // Flags persist through stack error resets; only rst_n (power-on) or a software pointer write clears them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      full_q <= 1'b0;
      unf_q <= 1'b0;
    end else begin
      full_q <= full_d;
      unf_q <= unf_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign pc_out = pc_q;
  assign instruction_register = ir_q;
  assign flush_active = flush_q;
  assign phase_out = phase_q;
  assign data_read_strobe = rd_strb_q;
  assign data_write_strobe = wr_strb_q;
  assign restore_valid = restore_q;
  assign status_restore = sh_stat_q;
  assign working_restore = sh_work_q;
  assign bank_restore = sh_bank_q;
  assign stack_reset_req = rst_req_q;

  // Stack pointer, storage and flag checks
  AST_PC_EVEN: assert property (@(posedge clk) disable iff (!rst_n) pc_q[0] == 1'b0)
    else $error("PC bit zero set");
  AST_SP_RANGE: assert property (@(posedge clk) disable iff (!rst_n) sp_q <= SP_MAX)
    else $error("Pointer out of range");
  AST_PUSH_INC: assert property (@(posedge clk) disable iff (!rst_n)
    do_push && !rst_req_q && sp_q < 5'h1D |=> sp_q == $past(sp_q) + 5'h01)
    else $error("Push did not increment");
  AST_PUSH_STORE: assert property (@(posedge clk) disable iff (!rst_n)
    do_push && !rst_req_q && sp_q < 5'h1E |=> stack_q[$past(sp_q)] == $past(pc_q))
    else $error("Push did not store PC");
  AST_POP_DEC: assert property (@(posedge clk) disable iff (!rst_n)
    do_pop && !rst_req_q && sp_q != SP_ZERO |=> sp_q == $past(sp_q) - 5'h01)
    else $error("Pop did not decrement");
  AST_HW_WINS: assert property (@(posedge clk) disable iff (!rst_n)
    do_pop && reg_wr && reg_addr == REG_SP && !rst_req_q && sp_q != SP_ZERO |=> sp_q == $past(sp_q) - 5'h01)
    else $error("Software write beat pop");
  AST_UNF_SET: assert property (@(posedge clk) disable iff (!rst_n)
    do_pop && !rst_req_q && sp_q == SP_ZERO |=> unf_q && sp_q == SP_ZERO)
    else $error("Underflow not flagged");
  AST_FULL_RESET: assert property (@(posedge clk) disable iff (!rst_n)
    do_push && !rst_req_q && cfg_q && sp_q == 5'h1E |=> full_q && rst_req_q ##1 sp_q == SP_ZERO)
    else $error("Full reset sequence wrong");
  AST_FULL_STORE: assert property (@(posedge clk) disable iff (!rst_n)
    do_push && !rst_req_q && cfg_q && sp_q == 5'h1E |=> stack_q[DEPTH-1] == $past(pc_q) + PC_STEP)
    else $error("Full push did not store PC plus two");
  AST_FULL_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    do_push && !rst_req_q && !cfg_q && sp_q == SP_MAX |=> sp_q == SP_MAX && full_q)
    else $error("Pointer left 31");
  AST_FULL_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
    full_q && !(reg_wr && reg_addr == REG_SP && !reg_wdata[FULL_BIT]) |=> full_q)
    else $error("Full flag lost");
  AST_UNF_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
    unf_q && !(reg_wr && reg_addr == REG_SP && !reg_wdata[UNF_BIT]) |=> unf_q)
    else $error("Underflow flag lost");
  AST_NO_ERR_RST: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg_q |=> !rst_req_q)
    else $error("Error reset while disabled");
  AST_UNF_RESET: assert property (@(posedge clk) disable iff (!rst_n)
    do_pop && !rst_req_q && cfg_q && sp_q == SP_ZERO |=> rst_req_q && unf_q)
    else $error("Underflow reset missing");
  AST_SP_BIT5: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == REG_SP |=> rdata_q[5] == 1'b0)
    else $error("Pointer bit 5 not zero");
  AST_TOS_VIEW: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == REG_TOS_LOW && sp_q != SP_ZERO |=> rdata_q == $past(stack_q[idx][7:0]))
    else $error("Top entry not shown");
  AST_ZERO_SLOT: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == REG_TOS_UPPER && sp_q == SP_ZERO |=> rdata_q == BYTE_ZERO)
    else $error("Level zero has storage");

  // Program counter checks
  AST_PCL_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == REG_PC_LOW && !exec_q4 && !rst_req_q |=> pc_q[15:8] == $past(hold_high_q))
    else $error("Holding not transferred");
  AST_PCL_READ: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == REG_PC_LOW && !rst_req_q |=> hold_high_q == $past(pc_q[15:8]))
    else $error("PC not copied to holding");
  AST_UPPER_W: assert property (@(posedge clk) disable iff (!rst_n) hold_upper_q[7:5] == 3'b000)
    else $error("Upper holding too wide");
  AST_JUMP: assert property (@(posedge clk) disable iff (!rst_n)
    exec_q4 && jump_req && !pop_req && !rst_req_q |=> pc_q == {$past(jump_target[PC_W-1:1]), 1'b0})
    else $error("Jump target not loaded");
  AST_PC_STEP: assert property (@(posedge clk) disable iff (!rst_n)
    phase_q == Q4 && !exec_q4 && !reg_wr && !rst_req_q |=> pc_q == $past(pc_q) + PC_STEP)
    else $error("PC did not step by two");

  // Pipeline and shadow checks
  AST_PHASE: assert property (@(posedge clk) disable iff (!rst_n)
    phase_q == Q1 && !rst_req_q |=> phase_q == Q2 ##1 phase_q == Q3)
    else $error("Phase order wrong");
  AST_IR_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
    phase_q == Q4 && !rst_req_q |=> ir_q == $past(fetch_data))
    else $error("Instruction not latched");
  AST_RD_STROBE: assert property (@(posedge clk) disable iff (!rst_n) rd_strb_q |-> phase_q == Q2)
    else $error("Read strobe off Q2");
  AST_WR_STROBE: assert property (@(posedge clk) disable iff (!rst_n) wr_strb_q |-> phase_q == Q4)
    else $error("Write strobe off Q4");
  AST_FLUSH: assert property (@(posedge clk) disable iff (!rst_n)
    exec_q4 && (jump_req || do_pop) && !rst_req_q |=> flush_q)
    else $error("Branch did not flush");
  AST_SHADOW: assert property (@(posedge clk) disable iff (!rst_n)
    exec_q4 && (irq_vector || fast_call) && !rst_req_q |=> sh_stat_q == $past(status_in) &&
    sh_work_q == $past(working_in) && sh_bank_q == $past(bank_in))
    else $error("Shadow not captured");
  AST_RESTORE: assert property (@(posedge clk) disable iff (!rst_n)
    exec_q4 && fast_return && !rst_req_q |=> restore_q)
    else $error("Fast return not signalled");

  COV_PUSH: cover property (@(posedge clk) disable iff (!rst_n) do_push);
  COV_UNDERFLOW: cover property (@(posedge clk) disable iff (!rst_n) do_pop && sp_q == SP_ZERO);
  COV_ERR_RESET: cover property (@(posedge clk) disable iff (!rst_n) rst_req_q);
  COV_FAST_RET: cover property (@(posedge clk) disable iff (!rst_n) restore_q);
  COV_FULL_HOLD: cover property (@(posedge clk) disable iff (!rst_n) do_push && sp_q == SP_MAX);
endmodule
`default_nettype wire

// ### bench/decoder_model.sv
// Behavioural instruction decoder feeding the flow control block
`timescale 1ns/1ns
`default_nettype none
module decoder_model
  import flow_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench command
  input wire logic arm,
  input wire logic [5:0] cmd,
  output logic busy,
  // Core side
  input wire logic [1:0] phase_out,
  input wire logic flush_active,
  output logic [5:0] req,
  output logic [15:0] fetch_data
);
  import flow_pkg::*;
  logic busy_q;
  logic [15:0] word_q;
  // Request held until a non-flushed Q4 edge takes it, as a stalled decoder would
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      word_q <= 16'h0000;
    end else begin
      word_q <= ~word_q + 16'h1357;
      if (arm) begin
        busy_q <= 1'b1;
      end else if (busy_q && phase_out == Q4 && !flush_active) begin
        busy_q <= 1'b0;
      end
    end
  end
  assign busy = busy_q;
  assign req = busy_q ? cmd : 6'h00;
  assign fetch_data = word_q;
endmodule
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the return stack and program counter block
`timescale 1ns/1ns
`default_nettype none
module tb;
  import flow_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, arm = 1'b0, busy, rd_seen = 1'b0;
  logic [5:0] cmd = 6'h00, req;
  logic [15:0] fetch_data;
  logic [7:0] status_in = 8'h00, working_in = 8'h00, bank_in = 8'h00;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, sr, wk, bk;
  logic reg_wr = 1'b0, reg_rd = 1'b0, flush_active, restore_valid, stack_reset_req;
  logic [1:0] phase_out;
  logic [15:0] ir, ir_exp = 16'h0000;
  logic ds_rd, ds_wr, ir_pend = 1'b0;
  pc_t jump_target = PC_ZERO, pc_out;
  logic [7:0] rdq[$];
  logic [23:0] rsq[$];
  int miscompares = 0, total_checks = 0, resets_seen = 0, flushes_seen = 0, cyc = 0;
  integer seed = 32'h5f1e31bb;
  always #25 clk = ~clk;
  decoder_model partner (.clk(clk), .rst_n(rst_n), .arm(arm), .cmd(cmd), .busy(busy),
    .phase_out(phase_out), .flush_active(flush_active), .req(req), .fetch_data(fetch_data));
  return_stack_and_pc_control dut (.clk(clk), .rst_n(rst_n), .push_req(req[5]), .pop_req(req[4]),
    .irq_vector(req[3]), .fast_call(req[2]), .fast_return(req[1]), .jump_req(req[0]),
    .jump_target(jump_target), .fetch_data(fetch_data), .status_in(status_in),
    .working_in(working_in), .bank_in(bank_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pc_out(pc_out),
    .instruction_register(ir), .flush_active(flush_active), .phase_out(phase_out),
    .data_read_strobe(ds_rd), .data_write_strobe(ds_wr), .restore_valid(restore_valid),
    .status_restore(sr), .working_restore(wk), .bank_restore(bk), .stack_reset_req(stack_reset_req));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rdq.push_back(e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  // Bits: push, pop, irq, fast call, fast return, jump
  task automatic op(input logic [5:0] c);
    int n = 0;
    @(posedge clk);
    cmd <= c;
    arm <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
    #1;
    while (busy && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(busy, 0, "request not taken");
    repeat (8) @(posedge clk);
  endtask
  // Read data stand only in the cycle after the strobe, so sample exactly there
  always @(posedge clk) begin
    cyc++;
    if (rd_seen) chk(reg_rdata, rdq.pop_front(), "register read"); // read path
    if (restore_valid) chk({sr, wk, bk}, rsq.pop_front(), "shadow restore"); // restore
    if (ir_pend) chk(ir, ir_exp, "instruction latch");
    if (ds_rd) chk(phase_out, Q2, "read strobe phase");
    if (ds_wr) chk(phase_out, Q4, "write strobe phase");
    ir_pend <= rst_n && phase_out == Q4;
    ir_exp <= fetch_data;
    if (stack_reset_req) resets_seen++;
    if (flush_active) flushes_seen++;
    rd_seen <= reg_rd;
    if (cyc == 20000) begin
      chk(0, 1, "timeout");
      results();
    end
  end
  initial begin
    logic [7:0] h, u;
    logic [23:0] v;
    int f0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(REG_SP, 8'h00); // pointer at reset
    rd(REG_CONFIG, 8'h01); // error reset on by default
    rd(4'hB, 8'h00);
    $display("reset values done");
    repeat (4) begin
      h = $random(seed);
      wr(REG_SP, h | 8'hE0);
      rd(REG_SP, h & 8'h1F); // flags not settable, bit 5 zero
    end
    $display("pointer access done");
    wr(REG_SP, 8'h00);
    op(6'h20);
    rd(REG_SP, 8'h01); // push raises pointer
    for (int i = 1; i < 4; i++) begin
      h = $random(seed);
      if (i == 3) h = h & 8'h1F;
      wr(i[3:0], h);
      rd(i[3:0], h); // top entry replaced
    end
    op(6'h10);
    rd(REG_SP, 8'h00); // pop only lowers pointer
    $display("push and pop done");
    wr(REG_CONFIG, 8'h00);
    op(6'h10);
    rd(REG_SP, 8'h40); // underflow flag, pointer kept
    chk(resets_seen, 0, "reset while disabled"); // flag only
    wr(REG_SP, 8'h1E);
    op(6'h20);
    rd(REG_SP, 8'h9F); // full at level 31
    op(6'h20);
    rd(REG_SP, 8'h9F); // pointer stays 31
    wr(REG_SP, 8'h00);
    rd(REG_SP, 8'h00); // software clear
    wr(REG_CONFIG, 8'h01);
    wr(REG_SP, 8'h1E);
    op(6'h20);
    chk(resets_seen, 1, "full reset"); // error reset
    rd(REG_SP, 8'h80); // flag kept, pointer 0
    op(6'h10);
    chk(resets_seen, 2, "underflow reset"); // error reset
    rd(REG_SP, 8'hC0); // both flags held
    wr(REG_SP, 8'h00);
    $display("stack errors done");
    h = $random(seed);
    u = $random(seed) & 8'h1F;
    wr(REG_PC_HIGH_HOLD, h);
    wr(REG_PC_UPPER_HOLD, u);
    // Align to Q1 so the number of PC steps before the read is fixed
    do begin
      @(posedge clk);
      #1;
    end while (phase_out != Q1);
    wr(REG_PC_LOW, 8'h10);
    wr(REG_PC_HIGH_HOLD, ~h);
    wr(REG_PC_UPPER_HOLD, ~u & 8'h1F);
    rd(REG_PC_LOW, 8'h12); // one step since the write
    rd(REG_PC_HIGH_HOLD, h); // read copies high byte
    rd(REG_PC_UPPER_HOLD, u); // read copies upper byte
    repeat (4) @(posedge clk);
    chk(pc_out[20:8], {u[4:0], h}, "pc upper bits"); // holding copied
    v = $random(seed);
    jump_target <= {v[12:0], 8'h20};
    f0 = flushes_seen;
    op(6'h01);
    chk(pc_out[20:8], v[12:0], "jump target"); // direct load
    chk(pc_out[0], 0, "pc lsb"); // word aligned
    chk(flushes_seen > f0, 1, "no flush"); // forced no-op
    rd(REG_PC_HIGH_HOLD, h); // holding untouched
    rd(REG_PC_UPPER_HOLD, u); // holding untouched
    $display("program counter done");
    for (int i = 0; i < 2; i++) begin
      v = $random(seed);
      {status_in, working_in, bank_in} <= v;
      rsq.push_back(v);
      op(i == 0 ? 6'h04 : 6'h08); // capture on fast call and vector
      {status_in, working_in, bank_in} <= ~v;
      op(6'h02); // fast return restores
    end
    chk(rsq.size(), 0, "restore missing"); // one restore each
    chk(rdq.size(), 0, "read missing");
    $display("shadow done");
    results();
  end
endmodule
`default_nettype wire
